// >>> hdl/droc_relay_top.sv
// dual relay output controller: registers, front panel menu, two channels
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module droc_relay_top #(
  parameter int unsigned MS_CYCLES = droc_pkg::MS_CYCLES,
  parameter int unsigned LONG_PRESS_CYCLES = droc_pkg::LONG_PRESS_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // front panel
  input wire logic key_sel_n,
  input wire logic key_ok_n,
  input wire logic setup_unlocked,
  output logic relay_menu_active,
  output logic relay_menu_exit,
  // measurements from the metering core
  input wire logic [15:0] meas_volt,
  input wire logic [15:0] meas_curr,
  input wire logic [15:0] meas_power,
  // relay drives and interrupt
  output logic relay_channel_one,
  output logic relay_channel_two,
  output logic irq
);
  import droc_pkg::*;

  // ==========================================================
  // shared helpers
  // full scale of the selected quantity
  function automatic logic [15:0] thr_max(input logic [1:0] q);
    case (q)
      QTY_VOLT: thr_max = VOLT_MAX;
      QTY_CURR: thr_max = CURR_MAX;
      default: thr_max = POWER_MAX;
    endcase
  endfunction : thr_max
  // pulse width forced into its legal window
  function automatic logic [12:0] clamp_pulse(input logic [12:0] v);
    if (v < PULSE_MIN_MS) clamp_pulse = PULSE_MIN_MS;
    else if (v > PULSE_MAX_MS) clamp_pulse = PULSE_MAX_MS;
    else clamp_pulse = v;
  endfunction : clamp_pulse

  // ==========================================================
  // channel settings, index 0 is channel one
  logic [1:0] relay_mode_q [2];
  logic [12:0] pulse_width_q [2];
  logic [1:0] alarm_quantity_q [2];
  logic alarm_compare_q [2];
  logic [15:0] alarm_threshold_q [2];
  logic [7:0] alarm_hold_time_q [2];
  logic latch_cmd_q [2]; // latch mode relay state from software
  logic trig_q [2]; // one-cycle pulse trigger
  logic relay_w [2];
  logic alarm_w [2];
  // bus handshake
  logic ack_q; // second cycle of an access
  logic bus_wr; // write takes effect this edge
  logic bus_rd; // read completes this edge
  logic [31:0] rd_mux;
  logic [31:0] be_mask;
  logic [31:0] wr_val;
  logic ch_a; // channel addressed by the bus
  // interrupts
  logic [3:0] irq_status_q;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_ev;
  logic relay_prev_q [2];
  logic alarm_prev_q [2];
  // front panel
  logic sel_hit;
  logic ok_hit;
  logic ok_long;
  logic both_hit;
  droc_menu_t menu_q;
  droc_menu_t menu_d;
  logic menu_ch_q;
  logic menu_ch_d;
  logic [15:0] edit_q; // value shown on the current screen
  logic [15:0] load_val;
  logic [15:0] step_val;
  logic commit; // panel accepts edit_q into the current field

  // ==========================================================
  // avalon slave: one wait state on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign bus_wr = avs_write & ack_q;
  assign bus_rd = avs_read & ack_q;
  assign ch_a = avs_address[4];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ack_q <= 1'b0;
    else ack_q <= (avs_read | avs_write) & ~ack_q;
  end
  // read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0;
    if (!avs_address[5]) begin
      case ({2'h0, avs_address[3:0]})
        REG_CH_CTRL: rd_mux = {26'h0, latch_cmd_q[ch_a], alarm_quantity_q[ch_a],
                               alarm_compare_q[ch_a], relay_mode_q[ch_a]};
        REG_CH_PULSE: rd_mux = {19'h0, pulse_width_q[ch_a]};
        REG_CH_THR: rd_mux = {16'h0, alarm_threshold_q[ch_a]};
        REG_CH_HOLD: rd_mux = {24'h0, alarm_hold_time_q[ch_a]};
        default: rd_mux = 32'h0;
      endcase
    end else begin
      case (avs_address)
        REG_STATUS: rd_mux = {27'h0, relay_menu_active, alarm_w[1], alarm_w[0],
                              relay_w[1], relay_w[0]};
        REG_IRQ_STATUS: rd_mux = {28'h0, irq_status_q};
        REG_IRQ_MASK: rd_mux = {28'h0, irq_mask_q};
        default: rd_mux = 32'h0;
      endcase
    end
    be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wr_val = (rd_mux & ~be_mask) | (avs_writedata & be_mask);
  end
  // read data captured in the wait cycle, stands at the completing edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) avs_readdata <= 32'h0;
    else if (avs_read && !ack_q) avs_readdata <= rd_mux;
  end

  // ==========================================================
  // settings: bus writes win over a panel commit in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        relay_mode_q[i] <= MODE_LATCH;
        pulse_width_q[i] <= PULSE_MIN_MS;
        alarm_quantity_q[i] <= QTY_NONE;
        alarm_compare_q[i] <= CMP_BELOW;
        alarm_threshold_q[i] <= THR_RST;
        alarm_hold_time_q[i] <= HOLD_RST;
        latch_cmd_q[i] <= 1'b0;
        trig_q[i] <= 1'b0;
      end
    end else begin
      trig_q[0] <= 1'b0;
      trig_q[1] <= 1'b0;
      if (bus_wr && !avs_address[5]) begin
        case ({2'h0, avs_address[3:0]})
          REG_CH_CTRL: begin
            if (wr_val[1:0] <= MODE_ALARM) relay_mode_q[ch_a] <= wr_val[1:0];
            alarm_compare_q[ch_a] <= wr_val[CTRL_CMP_BIT];
            alarm_quantity_q[ch_a] <= wr_val[CTRL_QTY_LSB +: 2];
            latch_cmd_q[ch_a] <= wr_val[CTRL_LATCH_BIT];
            trig_q[ch_a] <= wr_val[CTRL_TRIG_BIT] & avs_byteenable[0];
          end
          REG_CH_PULSE: pulse_width_q[ch_a] <= clamp_pulse(wr_val[12:0]);
          REG_CH_THR: begin
            if (wr_val[15:0] > thr_max(alarm_quantity_q[ch_a])) begin
              alarm_threshold_q[ch_a] <= thr_max(alarm_quantity_q[ch_a]);
            end else begin
              alarm_threshold_q[ch_a] <= wr_val[15:0];
            end
          end
          REG_CH_HOLD: alarm_hold_time_q[ch_a] <= wr_val[7:0];
          default: ;
        endcase
      end else if (commit) begin
        case (menu_q)
          M_MODE: relay_mode_q[menu_ch_q] <= edit_q[1:0];
          M_PULSE: pulse_width_q[menu_ch_q] <= edit_q[12:0];
          M_QTY: alarm_quantity_q[menu_ch_q] <= edit_q[1:0];
          M_CMP: alarm_compare_q[menu_ch_q] <= edit_q[0];
          M_THR: alarm_threshold_q[menu_ch_q] <= edit_q;
          M_HOLD: alarm_hold_time_q[menu_ch_q] <= edit_q[7:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // front panel buttons
  droc_keys #(
    .LONG_CYCLES(LONG_PRESS_CYCLES)
  ) u_keys (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .key_sel_n(key_sel_n),
    .key_ok_n(key_ok_n),
    .sel_hit(sel_hit),
    .ok_hit(ok_hit),
    .ok_long(ok_long),
    .both_hit(both_hit)
  );

  // ==========================================================
  // menu walk: mode screen, then the screens the chosen mode uses
  assign commit = ok_hit && (menu_q != M_IDLE) && !both_hit;
  always_comb begin
    menu_d = menu_q;
    menu_ch_d = menu_ch_q;
    if (menu_q == M_IDLE) begin
      if (setup_unlocked && ok_long) begin
        menu_d = M_MODE;
        menu_ch_d = 1'b0;
      end
    end else if (both_hit || !setup_unlocked) begin
      menu_d = M_IDLE;
    end else if (ok_hit) begin
      case (menu_q)
        M_MODE: begin
          if (edit_q[1:0] == MODE_PULSE) menu_d = M_PULSE;
          else if (edit_q[1:0] == MODE_ALARM) menu_d = M_QTY;
          else if (menu_ch_q) menu_d = M_IDLE;
          else menu_ch_d = 1'b1;
        end
        M_QTY: menu_d = M_CMP;
        M_CMP: menu_d = M_THR;
        M_THR: menu_d = M_HOLD;
        default: begin
          // pulse or hold screen closes the channel
          if (menu_ch_q) begin
            menu_d = M_IDLE;
          end else begin
            menu_d = M_MODE;
            menu_ch_d = 1'b1;
          end
        end
      endcase
    end
  end
  // value loaded when a screen opens
  always_comb begin
    case (menu_d)
      M_MODE: load_val = {14'h0, relay_mode_q[menu_ch_d]};
      M_PULSE: load_val = {3'h0, pulse_width_q[menu_ch_d]};
      M_QTY: load_val = {14'h0, alarm_quantity_q[menu_ch_d]};
      M_CMP: load_val = {15'h0, alarm_compare_q[menu_ch_d]};
      M_THR: load_val = alarm_threshold_q[menu_ch_d];
      M_HOLD: load_val = {8'h0, alarm_hold_time_q[menu_ch_d]};
      default: load_val = 16'h0;
    endcase
  end
  // select steps the value and wraps inside its range
  always_comb begin
    step_val = edit_q;
    case (menu_q)
      M_MODE: step_val = (edit_q[1:0] >= MODE_ALARM) ? 16'h0 : edit_q + 16'h1;
      M_PULSE: begin
        if (edit_q[12:0] >= PULSE_MAX_MS) step_val = {3'h0, PULSE_MIN_MS};
        else step_val = edit_q + {3'h0, PULSE_STEP_MS};
      end
      M_QTY: step_val = {14'h0, edit_q[1:0] + 2'h1};
      M_CMP: step_val = {15'h0, ~edit_q[0]};
      M_THR: begin
        if (edit_q > thr_max(alarm_quantity_q[menu_ch_q]) - THR_STEP) step_val = 16'h0;
        else step_val = edit_q + THR_STEP;
      end
      M_HOLD: step_val = (edit_q[7:0] == HOLD_MAX_S) ? 16'h0 : edit_q + 16'h1;
      default: step_val = edit_q;
    endcase
  end
  // menu state, edit value and exit pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      menu_q <= M_IDLE;
      menu_ch_q <= 1'b0;
      edit_q <= 16'h0;
      relay_menu_exit <= 1'b0;
    end else begin
      menu_q <= menu_d;
      menu_ch_q <= menu_ch_d;
      relay_menu_exit <= (menu_q != M_IDLE) && (menu_d == M_IDLE);
      if (menu_d != menu_q || menu_ch_d != menu_ch_q) edit_q <= load_val;
      else if (sel_hit && menu_q != M_IDLE) edit_q <= step_val;
    end
  end
  assign relay_menu_active = (menu_q != M_IDLE);

  // ==========================================================
  // the two channels
  for (genvar g = 0; g < 2; g++) begin : g_ch
    droc_channel #(
      .MS_CYC(MS_CYCLES)
    ) u_ch (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .mode(relay_mode_q[g]),
      .pulse_ms(pulse_width_q[g]),
      .quantity(alarm_quantity_q[g]),
      .compare(alarm_compare_q[g]),
      .threshold(alarm_threshold_q[g]),
      .hold_s(alarm_hold_time_q[g]),
      .latch_on(latch_cmd_q[g]),
      .trigger(trig_q[g]),
      .meas_volt(meas_volt),
      .meas_curr(meas_curr),
      .meas_power(meas_power),
      .relay_q(relay_w[g]),
      .alarm_q(alarm_w[g])
    );
  end
  assign relay_channel_one = relay_w[0];
  assign relay_channel_two = relay_w[1];

  // ==========================================================
  // interrupts: {alarm2, alarm1, relay2, relay1} changed
  assign irq_ev = {alarm_w[1] ^ alarm_prev_q[1], alarm_w[0] ^ alarm_prev_q[0],
                   relay_w[1] ^ relay_prev_q[1], relay_w[0] ^ relay_prev_q[0]};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_prev_q[0] <= 1'b0;
      relay_prev_q[1] <= 1'b0;
      alarm_prev_q[0] <= 1'b0;
      alarm_prev_q[1] <= 1'b0;
      irq_status_q <= 4'h0;
      irq_mask_q <= 4'h0;
    end else begin
      relay_prev_q <= relay_w;
      alarm_prev_q <= alarm_w;
      // a read clears only what it returned; a new event still sets
      if (bus_rd && avs_address == REG_IRQ_STATUS) begin
        irq_status_q <= (irq_status_q & ~avs_readdata[3:0]) | irq_ev;
      end else begin
        irq_status_q <= irq_status_q | irq_ev;
      end
      if (bus_wr && avs_address == REG_IRQ_MASK) irq_mask_q <= wr_val[3:0];
    end
  end
  assign irq = |(irq_status_q & irq_mask_q);
endmodule : droc_relay_top

// >>> hdl/droc_pkg.sv
// constants and types shared by the dual relay output controller
package droc_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned LONG_PRESS_S = 3;
  localparam int unsigned LONG_PRESS_CYCLES = LONG_PRESS_S * CLK_HZ;
  localparam logic [17:0] MS_PER_S_W = 18'h003e8;
  // ==========================================================
  // mode, quantity and comparison codes
  localparam logic [1:0] MODE_LATCH = 2'h0;
  localparam logic [1:0] MODE_PULSE = 2'h1;
  localparam logic [1:0] MODE_ALARM = 2'h2;
  localparam logic [1:0] QTY_NONE = 2'h0;
  localparam logic [1:0] QTY_VOLT = 2'h1;
  localparam logic [1:0] QTY_CURR = 2'h2;
  localparam logic [1:0] QTY_POWER = 2'h3;
  localparam logic CMP_BELOW = 1'b0;
  // ==========================================================
  // ranges, steps and reset values
  localparam logic [12:0] PULSE_MIN_MS = 13'h012c;
  localparam logic [12:0] PULSE_MAX_MS = 13'h1388;
  localparam logic [12:0] PULSE_STEP_MS = 13'h0064;
  localparam logic [15:0] VOLT_MAX = 16'h0bb8;
  localparam logic [15:0] CURR_MAX = 16'hc350;
  localparam logic [15:0] POWER_MAX = 16'hea60;
  localparam logic [15:0] THR_STEP = 16'h000a;
  localparam logic [7:0] HOLD_MAX_S = 8'hff;
  localparam logic [15:0] THR_RST = 16'h0000;
  localparam logic [7:0] HOLD_RST = 8'h00;
  // ==========================================================
  // register map, byte offsets; channel two adds CH_STRIDE
  localparam logic [5:0] REG_CH_CTRL = 6'h00;
  localparam logic [5:0] REG_CH_PULSE = 6'h04;
  localparam logic [5:0] REG_CH_THR = 6'h08;
  localparam logic [5:0] REG_CH_HOLD = 6'h0c;
  localparam logic [5:0] CH_STRIDE = 6'h10;
  localparam logic [5:0] REG_STATUS = 6'h20;
  localparam logic [5:0] REG_IRQ_STATUS = 6'h24;
  localparam logic [5:0] REG_IRQ_MASK = 6'h28;
  // control word fields
  localparam int CTRL_CMP_BIT = 2;
  localparam int CTRL_QTY_LSB = 3;
  localparam int CTRL_LATCH_BIT = 5;
  localparam int CTRL_TRIG_BIT = 6;
  // ==========================================================
  // front panel menu screens
  typedef enum logic [6:0] {
    M_IDLE = 7'b0000001,
    M_MODE = 7'b0000010,
    M_PULSE = 7'b0000100,
    M_QTY = 7'b0001000,
    M_CMP = 7'b0010000,
    M_THR = 7'b0100000,
    M_HOLD = 7'b1000000
  } droc_menu_t;
endpackage : droc_pkg

// >>> hdl/droc_keys.sv
// two-button front panel conditioner: sync, press, both-press, long press
`timescale 1ns/1ps
module droc_keys #(
  parameter int unsigned LONG_CYCLES = droc_pkg::LONG_PRESS_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // buttons, low while pressed
  input wire logic key_sel_n,
  input wire logic key_ok_n,
  // one-cycle events
  output logic sel_hit,
  output logic ok_hit,
  output logic ok_long,
  output logic both_hit
);
  import droc_pkg::*;
  localparam int LW = $clog2(LONG_CYCLES + 1);
  logic [1:0] meta_q; // first stage, read only by sync_q
  logic [1:0] sync_q; // {ok, sel} pressed
  logic [1:0] prev_q;
  logic both_seen_q; // both went down since last all-up
  logic long_done_q; // long press already reported
  logic [LW-1:0] hold_q;
  // ==========================================================
  // two-flop synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
      prev_q <= 2'h0;
    end else begin
      meta_q <= {~key_ok_n, ~key_sel_n};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  // ==========================================================
  // chord and long-press tracking, single presses act on release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      both_seen_q <= 1'b0;
      long_done_q <= 1'b0;
      hold_q <= '0;
      sel_hit <= 1'b0;
      ok_hit <= 1'b0;
      ok_long <= 1'b0;
      both_hit <= 1'b0;
    end else begin
      both_hit <= (&sync_q) & ~both_seen_q;
      if (&sync_q) both_seen_q <= 1'b1;
      else if (sync_q == 2'h0) both_seen_q <= 1'b0;
      sel_hit <= prev_q[0] & ~sync_q[0] & ~both_seen_q;
      ok_hit <= prev_q[1] & ~sync_q[1] & ~both_seen_q & ~long_done_q;
      ok_long <= 1'b0;
      // ok held alone counts toward the long press
      if (sync_q == 2'h2 && !both_seen_q) begin
        if (hold_q == LW'(LONG_CYCLES - 1) && !long_done_q) begin
          ok_long <= 1'b1;
          long_done_q <= 1'b1;
        end else if (!long_done_q) begin
          hold_q <= hold_q + 1'b1;
        end
      end else begin
        hold_q <= '0;
        if (!sync_q[1]) long_done_q <= 1'b0;
      end
    end
  end
endmodule : droc_keys

// >>> hdl/droc_channel.sv
// one relay channel: latch, timed pulse or delayed alarm
`timescale 1ns/1ps
module droc_channel #(
  parameter int unsigned MS_CYC = droc_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // settings
  input wire logic [1:0] mode,
  input wire logic [12:0] pulse_ms,
  input wire logic [1:0] quantity,
  input wire logic compare,
  input wire logic [15:0] threshold,
  input wire logic [7:0] hold_s,
  // commands
  input wire logic latch_on,
  input wire logic trigger,
  // measurements
  input wire logic [15:0] meas_volt,
  input wire logic [15:0] meas_curr,
  input wire logic [15:0] meas_power,
  // state
  output logic relay_q,
  output logic alarm_q
);
  import droc_pkg::*;
  localparam int SW = $clog2(MS_CYC);
  logic [SW-1:0] sub_q; // cycles within a millisecond
  logic [17:0] ms_q; // elapsed milliseconds of the running timer
  logic [1:0] mode_prev_q;
  logic pulse_on_q;
  logic [15:0] meas;
  logic cond;
  logic running;
  logic [17:0] target;
  logic done;
  // ==========================================================
  // alarm condition, only in alarm mode and never for quantity none
  always_comb begin
    case (quantity)
      QTY_VOLT: meas = meas_volt;
      QTY_CURR: meas = meas_curr;
      default: meas = meas_power;
    endcase
    cond = 1'b0;
    if (mode == MODE_ALARM && quantity != QTY_NONE) begin
      cond = (compare == CMP_BELOW) ? (meas < threshold) : (meas > threshold);
    end
  end
  // ==========================================================
  // one timer serves the pulse width or the hold delay
  always_comb begin
    running = 1'b0;
    target = {5'h00, pulse_ms};
    if (mode == MODE_PULSE) begin
      running = pulse_on_q;
    end else if (mode == MODE_ALARM) begin
      running = (cond != alarm_q);
      target = 18'(hold_s * MS_PER_S_W);
    end
    done = running && ((target == 18'h0) ||
           (sub_q == SW'(MS_CYC - 1) && ms_q == target - 18'h1));
  end
  // timer clears whenever it is not running, so a condition that flips back restarts it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_q <= '0;
      ms_q <= 18'h0;
    end else if (!running || done || mode != mode_prev_q) begin
      sub_q <= '0;
      ms_q <= 18'h0;
    end else if (sub_q == SW'(MS_CYC - 1)) begin
      sub_q <= '0;
      ms_q <= ms_q + 18'h1;
    end else begin
      sub_q <= sub_q + 1'b1;
    end
  end
  // ==========================================================
  // pulse and alarm state, dropped on any mode change
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_prev_q <= MODE_LATCH;
      pulse_on_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      mode_prev_q <= mode;
      // outside pulse mode the pulse is already low, so a trigger sent with the mode still starts it
      if (mode != MODE_PULSE) pulse_on_q <= 1'b0;
      else if (done) pulse_on_q <= 1'b0;
      else if (trigger) pulse_on_q <= 1'b1;
      if (mode != MODE_ALARM) alarm_q <= 1'b0;
      else if (done) alarm_q <= cond;
    end
  end
  // relay drive, one cycle behind the state so every mode has the same lag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_q <= 1'b0;
    end else begin
      case (mode)
        MODE_LATCH: relay_q <= latch_on;
        MODE_PULSE: relay_q <= pulse_on_q;
        MODE_ALARM: relay_q <= alarm_q;
        default: relay_q <= 1'b0;
      endcase
    end
  end
endmodule : droc_channel

// >>> verification/droc_relay_sva.sv
// port checker for the dual relay output controller
`timescale 1ns/1ps
module droc_relay_sva (
  // clock, reset and watched ports
  input wire logic ref_clk,
  input wire logic rst_n,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  // front panel and outputs
  input wire logic key_ok_n,
  input wire logic setup_unlocked,
  input wire logic relay_menu_active,
  input wire logic relay_menu_exit,
  input wire logic relay_channel_one,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // bus handshake: at most one wait state, none while idle, data held over it
  wait_one_a: assert property ((avs_read | avs_write) & avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait state");
  idle_wait_a: assert property (!avs_read & !avs_write |-> !avs_waitrequest)
    else $error("wait raised with no access");
  // data is loaded in the wait cycle and must stand past the completing edge
  read_hold_a: assert property (avs_read & !avs_waitrequest |=> $stable(avs_readdata))
    else $error("read data moved right after the completing edge");
  // ==========
  // front panel menu entry and exit
  entry_cause_a: assert property ($rose(relay_menu_active) |-> setup_unlocked && !$past(key_ok_n, 8))
    else $error("menu opened without a long confirm press");
  locked_stay_a: assert property (!relay_menu_active & !setup_unlocked |=> !relay_menu_active)
    else $error("menu opened while setup is locked");
  exit_pulse_a: assert property (relay_menu_exit |=> !relay_menu_exit)
    else $error("exit pulse longer than one cycle");
  exit_fall_a: assert property ($fell(relay_menu_active) |-> ##[0:1] relay_menu_exit)
    else $error("menu closed without an exit pulse");
  drop_leave_a: assert property (relay_menu_active & !setup_unlocked |-> ##[0:2] !relay_menu_active)
    else $error("menu kept open after setup was locked");
  // main scenarios reached
  menu_c: cover property ($rose(relay_menu_active));
  relay_c: cover property ($rose(relay_channel_one));
  irq_c: cover property ($rose(irq));
endmodule : droc_relay_sva
bind droc_relay_top droc_relay_sva i_droc_relay_sva (.*);

// >>> verification/droc_panel_model.sv
// front panel operator: presses and releases the two buttons
`timescale 1ns/1ps
module droc_panel_model (
  // clock and button pins, high while released
  input wire logic ref_clk,
  output logic key_sel_n = 1'b1,
  output logic key_ok_n = 1'b1
);
  // hold the chosen buttons n cycles, release, let the press settle
  task automatic push(input logic s, input logic o, input int n);
    @(posedge ref_clk);
    key_sel_n <= !s;
    key_ok_n <= !o;
    repeat (n) @(posedge ref_clk);
    key_sel_n <= 1'b1;
    key_ok_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : push
endmodule : droc_panel_model

// >>> verification/tb_droc_relay_top.sv
// self-checking bench for the dual relay output controller
`timescale 1ns/1ps
module tb_droc_relay_top;
  import droc_pkg::*;
  localparam int MSC = 4;
  logic ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, setup_unlocked = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, q;
  logic [3:0] avs_byteenable = 4'hf;
  logic [15:0] meas_volt = 16'h0, meas_curr = 16'h0, meas_power = 16'h0;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, key_sel_n, key_ok_n, relay_menu_active, relay_menu_exit, irq;
  wire logic relay_channel_one, relay_channel_two;
  int n_errors = 0, comparisons = 0, n, n_exit = 0;
  droc_relay_top #(.MS_CYCLES(MSC), .LONG_PRESS_CYCLES(20)) i_droc_relay_top (.*);
  droc_panel_model i_droc_panel_model (.*);
  initial forever #20 ref_clk = ~ref_clk;
  // count exit pulses
  always @(posedge ref_clk) n_exit <= n_exit + relay_menu_exit;
  // ==========
  // one bus access; request held until a rising edge sees wait low, data taken there
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cyc
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // watchdog
  initial begin
    #2000000;
    n_errors++;
    end_of_test();
  end
  // ==========
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, refused mode, unmapped place, independent channels
    acc(0, REG_CH_PULSE, 0);
    chk(q, 32'(PULSE_MIN_MS));
    acc(1, REG_CH_CTRL, 32'h3);
    acc(0, REG_CH_CTRL, 0);
    chk(q, 32'h0);
    acc(1, REG_CH_CTRL + CH_STRIDE, 32'h2);
    acc(0, REG_CH_CTRL + CH_STRIDE, 0);
    chk(q, 32'h2);
    acc(0, 6'h30, 0);
    chk(q, 32'h0);
    // latch relay, its interrupt, read-to-clear, mask
    acc(1, REG_IRQ_MASK, 32'h1);
    acc(1, REG_CH_CTRL, 32'h60);
    cyc(3);
    chk({relay_channel_one, irq}, 2'b11);
    acc(0, REG_STATUS, 0);
    chk(q, 32'h1);
    acc(0, REG_IRQ_STATUS, 0);
    chk(q, 32'h1);
    acc(0, REG_IRQ_STATUS, 0);
    chk({q[0], irq}, 2'b00);
    acc(1, REG_IRQ_MASK, 32'h0);
    acc(1, REG_CH_CTRL, 32'h40);
    cyc(3);
    chk({relay_channel_one, irq}, 2'b00);
    // pulse width clamped to the minimum, pulse length exact
    acc(1, REG_CH_PULSE, 32'h64);
    acc(0, REG_CH_PULSE, 0);
    chk(q, 32'(PULSE_MIN_MS));
    acc(1, REG_CH_CTRL, 32'h41);
    n = 0;
    repeat (1300) begin
      @(negedge ref_clk);
      n += relay_channel_one;
    end
    chk(n, PULSE_MIN_MS * MSC);
    // alarm above 100 V, one second hold, brief dip restarts it
    acc(1, REG_CH_THR, 32'h64);
    acc(1, REG_CH_HOLD, 32'h1);
    acc(1, REG_CH_CTRL, 32'h0e);
    meas_volt <= 16'h00c8;
    cyc(2000);
    @(posedge ref_clk);
    meas_volt <= 16'h0032;
    @(posedge ref_clk);
    meas_volt <= 16'h00c8;
    cyc(3990);
    chk(relay_channel_one, 1'b0);
    chk(relay_channel_two, 1'b0);
    cyc(20);
    chk(relay_channel_one, 1'b1);
    @(posedge ref_clk);
    meas_volt <= 16'h0032;
    cyc(3990);
    chk(relay_channel_one, 1'b1);
    cyc(20);
    chk(relay_channel_one, 1'b0);
    // channel two latched on by itself
    acc(1, REG_CH_CTRL + CH_STRIDE, 32'h20);
    cyc(3);
    chk({relay_channel_two, relay_channel_one}, 2'b10);
    // front panel: enter, step mode, confirm, leave
    acc(1, REG_CH_CTRL, 32'h0);
    setup_unlocked <= 1'b1;
    i_droc_panel_model.push(1'b0, 1'b1, 30);
    chk(relay_menu_active, 1'b1);
    i_droc_panel_model.push(1'b1, 1'b0, 3);
    i_droc_panel_model.push(1'b0, 1'b1, 3);
    acc(0, REG_CH_CTRL, 0);
    chk(q[1:0], MODE_PULSE);
    i_droc_panel_model.push(1'b1, 1'b1, 3);
    chk({relay_menu_active, n_exit[1:0]}, 3'b001);
    i_droc_panel_model.push(1'b0, 1'b1, 30);
    chk(relay_menu_active, 1'b1);
    setup_unlocked <= 1'b0;
    cyc(3);
    chk(relay_menu_active, 1'b0);
    end_of_test();
  end
endmodule : tb_droc_relay_top
